/* File: pkg/ocp_pkg.sv */
package ocp_pkg;

   // Command codes of the over-current group
   localparam logic [7:0] CMD_OC_LIMIT = 8'h46;
   localparam logic [7:0] CMD_OC_REACT = 8'h47;
   localparam logic [7:0] CMD_OC_LV_LIMIT = 8'h48;

   // Reset values
   localparam logic [15:0] OC_LIMIT_RST = 16'h0000;
   localparam logic [7:0] OC_REACT_RST = 8'h00;
   localparam logic [15:0] OC_LV_LIMIT_RST = 16'h0000;

   // Fault reaction field layout
   localparam int RESP_HI = 7;
   localparam int RESP_LO = 6;
   localparam int RETRY_HI = 5;
   localparam int RETRY_LO = 3;
   localparam int DELAY_HI = 2;
   localparam int DELAY_LO = 0;
   localparam int REACT_W = 8;

   localparam logic [2:0] RETRY_NONE = 3'h0;
   localparam logic [2:0] RETRY_ENDLESS = 3'h7;
   localparam logic [7:0] ONE_UNIT = 8'h01;

   typedef enum logic [1:0] {
      RESP_IGNORE = 2'h0,
      RESP_RUN_DELAY = 2'h1,
      RESP_OFF_RETRY = 2'h2,
      RESP_DISABLE_RETRY = 2'h3
   } resp_t;

   // Gray along on -> wait -> try -> latch
   typedef enum logic [2:0] {
      ST_ON = 3'h0,
      ST_HOLD = 3'h4,
      ST_WAIT = 3'h1,
      ST_TRY = 3'h3,
      ST_LATCH = 3'h2
   } state_t;

   typedef struct packed {
      logic [7:0] cmd;
      logic wr;
      logic rd;
      logic [15:0] wdata;
   } reg_req_t;

   typedef struct packed {
      logic ack;
      logic err;
      logic [15:0] rdata;
   } reg_rsp_t;

endpackage : ocp_pkg

/* File: verification/ocp_chk.sv */
module ocp_chk (
   input wire logic ref_clk,
   input wire logic nrst,
   input wire ocp_pkg::reg_req_t reg_req,
   input wire ocp_pkg::reg_rsp_t reg_rsp,
   input wire logic output_cmd_on,
   input wire logic other_fault_off,
   input wire logic clear_faults,
   input wire logic status_clear,
   input wire logic output_enable,
   input wire logic oc_fault_status,
   input wire logic host_notify,
   input wire logic [2:0] retry_count,
   input wire logic [15:0] oc_limit,
   input wire logic [15:0] oc_lv_limit
);
   timeunit 1ns;
   timeprecision 1ps;
   wire acc = reg_req.wr | reg_req.rd;
   wire mapped = reg_req.cmd inside {ocp_pkg::CMD_OC_LIMIT, ocp_pkg::CMD_OC_REACT,
      ocp_pkg::CMD_OC_LV_LIMIT};
   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (!nrst);
   ack_follows_a: assert property (acc |=> reg_rsp.ack)
      else $error("no ack after request");
   unmapped_err_a: assert property (acc && !mapped |=> reg_rsp.err && reg_rsp.rdata == 16'h0000)
      else $error("unmapped access not refused");
   limit_write_a: assert property (reg_req.wr && reg_req.cmd == ocp_pkg::CMD_OC_LIMIT
      |=> oc_limit == $past(reg_req.wdata))
      else $error("fault threshold not written");
   lv_write_a: assert property (reg_req.wr && reg_req.cmd == ocp_pkg::CMD_OC_LV_LIMIT
      |=> oc_lv_limit == $past(reg_req.wdata))
      else $error("low voltage threshold not written");
   notify_mirror_a: assert property (host_notify == oc_fault_status)
      else $error("notify differs from status");
   status_sticky_a: assert property (oc_fault_status && !clear_faults && !status_clear
      && output_cmd_on && $past(output_cmd_on) |=> oc_fault_status)
      else $error("status dropped without clear");
   cmd_off_a: assert property (!output_cmd_on [*2] |-> !output_enable && retry_count == 3'h0)
      else $error("output on while commanded off");
   other_off_a: assert property (other_fault_off [*2] |-> !output_enable)
      else $error("output on during other fault");
   count_step_a: assert property (retry_count != $past(retry_count) && retry_count != 3'h0
      |-> retry_count == $past(retry_count) + 3'h1 && output_enable)
      else $error("attempt count jumped");
   cover property (reg_rsp.err);
   cover property ($rose(output_enable) && retry_count == 3'h6);
   cover property (retry_count == 3'h7);
endmodule : ocp_chk

/* File: verification/ocp_host.sv */
module ocp_host (
   input wire logic ref_clk,
   output ocp_pkg::reg_req_t reg_req,
   input wire ocp_pkg::reg_rsp_t reg_rsp
);
   timeunit 1ns;
   timeprecision 1ps;
   initial reg_req = '0;
   // Released lines show inverted data so a stale capture shows up
   task automatic xfer(input logic [7:0] cmd, input logic wr, input logic [15:0] wd,
      output ocp_pkg::reg_rsp_t rsp);
      int n;
      @(negedge ref_clk);
      reg_req = '{cmd: cmd, wr: wr, rd: !wr, wdata: wd};
      @(negedge ref_clk);
      reg_req = '{cmd: ~cmd, wr: 1'b0, rd: 1'b0, wdata: ~wd};
      rsp = reg_rsp;
      n = 0;
      while (!rsp.ack && n < 4) begin
         @(negedge ref_clk);
         rsp = reg_rsp;
         n++;
      end
   endtask : xfer
endmodule : ocp_host

/* File: verification/tb_overcurrent_fault_retry_logic.sv */
module tb_overcurrent_fault_retry_logic;
   timeunit 1ns;
   timeprecision 1ps;
   logic ref_clk = 1'b0;
   logic nrst = 1'b0;
   logic pin = 1'b0;
   logic cmd_on = 1'b0;
   logic other = 1'b0;
   logic clr = 1'b0;
   logic st_clr = 1'b0;
   logic [15:0] unit = 16'h0002;
   ocp_pkg::reg_req_t reg_req;
   ocp_pkg::reg_rsp_t reg_rsp;
   ocp_pkg::reg_rsp_t rsp;
   logic oe, stat, notify, prev;
   logic [2:0] cnt;
   logic [15:0] lim, lv_lim;
   logic [7:0] react;
   int failures = 0;
   int compares = 0;
   int n, last, t;
   ocp_host host (.ref_clk(ref_clk), .reg_req(reg_req), .reg_rsp(reg_rsp));
   overcurrent_fault_retry_logic dut (.ref_clk(ref_clk), .nrst(nrst), .reg_req(reg_req),
      .reg_rsp(reg_rsp), .unit_cycles(unit), .oc_detect_pin(pin), .output_cmd_on(cmd_on),
      .other_fault_off(other), .clear_faults(clr), .status_clear(st_clr),
      .output_enable(oe), .oc_fault_status(stat), .host_notify(notify),
      .retry_count(cnt), .oc_limit(lim), .oc_lv_limit(lv_lim));
   initial forever #5 ref_clk = ~ref_clk;
   task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
      compares++;
      if (seen !== exp) begin
         failures++;
         $display("FAIL %s expected %h seen %h", what, exp, seen);
      end
   endtask : check
   task automatic test_done();
      $display("compares %0d failures %0d", compares, failures);
      if (failures == 0 && compares > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask : test_done
   task automatic tick(input int k);
      repeat (k) @(negedge ref_clk);
   endtask : tick
   task automatic wr(input logic [7:0] cmd, input logic [15:0] d);
      host.xfer(cmd, 1'b1, d, rsp);
      check("ack", {rsp.ack, rsp.err}, 16'h0002);
   endtask : wr
   task automatic rd(input logic [7:0] cmd, input logic [15:0] exp);
      host.xfer(cmd, 1'b0, 16'h0000, rsp);
      check("rd_ack", rsp.ack, 1'b1);
      check("rdata", rsp.rdata, exp);
   endtask : rd
   initial begin
      tick(16);
      nrst = 1'b1;
      cmd_on = 1'b1;
      tick(2);
      check("oe_on", oe, 1'b1);
      rd(ocp_pkg::CMD_OC_REACT, 16'h0000);
      wr(ocp_pkg::CMD_OC_LIMIT, 16'h1234);
      rd(ocp_pkg::CMD_OC_LIMIT, 16'h1234);
      wr(ocp_pkg::CMD_OC_LV_LIMIT, 16'hABCD);
      rd(ocp_pkg::CMD_OC_LV_LIMIT, 16'hABCD);
      host.xfer(8'h49, 1'b1, 16'h5555, rsp);
      check("unmapped", {rsp.err, rsp.rdata[14:0]}, 16'h8000);
      // Responses that keep running: ignore, then run on for the delay
      for (int r = 0; r < 2; r++) begin
         wr(ocp_pkg::CMD_OC_REACT, {8'h00, 2'(r), 6'h02});
         pin = 1'b1;
         n = 0;
         for (t = 0; t < 40; t++) begin
            if (t == (r == 1 ? 2 : 30))
               pin = 1'b0;
            tick(1);
            if (oe !== 1'b1)
               n++;
         end
         check("run_on", 16'(n), 16'h0000);
         check("status", stat, 1'b1);
         clr = 1'b1;
         tick(1);
         clr = 1'b0;
         tick(1);
         check("cleared", stat, 1'b0);
      end
      // Disable and retry, every retry code, delay code falling as retries rise
      for (int i = 0; i < 8; i++) begin
         react = {2'b11, 3'(i), 3'(7 - i)};
         wr(ocp_pkg::CMD_OC_REACT, {8'hA5, react});
         rd(ocp_pkg::CMD_OC_REACT, {8'h00, react});
         pin = 1'b1;
         n = 0;
         last = -1;
         prev = oe;
         for (t = 0; t < 300; t++) begin
            tick(1);
            if (prev && !oe && last < 0)
               last = t;
            if (!prev && oe) begin
               n++;
               check("spacing", 16'(t - last), 16'(2 << (7 - i)));
               last = t;
            end
            prev = oe;
         end
         if (i < 7) begin
            check("attempts", 16'(n), 16'(i));
            check("latched", oe, 1'b0);
         end
         else
            check("endless", 16'(n > 8), 16'h0001);
         check("notify", notify, 1'b1);
         // Endless case stays commanded on so the other-fault stop is seen alone
         cmd_on = (i == 7);
         other = (i == 7);
         pin = 1'b0;
         tick(4);
         check("off", {oe, 12'h000, cnt}, 16'h0000);
         other = 1'b0;
         cmd_on = 1'b1;
         tick(4);
         check("restart", {oe, 12'h000, cnt}, 16'h8000);
         st_clr = 1'b1;
         tick(1);
         st_clr = 1'b0;
         tick(1);
         check("st_clear", stat, 1'b0);
      end
      test_done();
   end
endmodule : tb_overcurrent_fault_retry_logic
bind overcurrent_fault_retry_logic ocp_chk chk (.ref_clk(ref_clk), .nrst(nrst),
   .reg_req(reg_req), .reg_rsp(reg_rsp), .output_cmd_on(output_cmd_on),
   .other_fault_off(other_fault_off), .clear_faults(clear_faults),
   .status_clear(status_clear), .output_enable(output_enable),
   .oc_fault_status(oc_fault_status), .host_notify(host_notify),
   .retry_count(retry_count), .oc_limit(oc_limit), .oc_lv_limit(oc_lv_limit));

/* File: verilog/overcurrent_fault_retry_logic.sv */
// Behaviour
// RULE1: Retry codes 100, 101, 110 give four, five, six restart attempts.
// RULE2: When all permitted attempts fail, output stays off until fault cleared.
// RULE3: Attempt starts are spaced by delay field times the configured time unit.
// RULE4: Code 111 retries endlessly until commanded off, bias lost, other fault. The code has no bias-loss input; only command off or other fault stop it.
// RULE5: Delay codes 0,1,3,4,5,6,7 select 1,2,8,16,32,64,128 time units.
// RULE6: Delay count serves as run-on time or restart spacing; unit set elsewhere.
// RULE7: Sixteen-bit over-current fault threshold register at command 0x46.
// RULE8: Response 11 shuts the output down then follows the retry setting.
// RULE9: Any over-current fault sets the status bit and notifies the host. The code does so only for a fault seen while output_enable is high.
// RULE10: Retry code 000 makes no attempt; output off until fault cleared.
// RULE11: Sixteen-bit over-current low-voltage threshold register at command 0x48.
// RULE12: Retry field bits 5:3 set the number of restart attempts.
// RULE13: Clear-faults, status clear, off-then-on command or bias loss clear faults. The code has no bias-loss input.
// RULE14: Delay code 2 selects four time units.
// RULE15: Attempt counter returns to zero on fault clear or command re-enable.
module overcurrent_fault_retry_logic #(
   parameter int UNIT_W = 16
) (
   input wire logic ref_clk,
   input wire logic nrst,
   input wire ocp_pkg::reg_req_t reg_req,
   output ocp_pkg::reg_rsp_t reg_rsp,
   input wire logic [UNIT_W-1:0] unit_cycles,
   input wire logic oc_detect_pin,
   input wire logic output_cmd_on,
   input wire logic other_fault_off,
   input wire logic clear_faults,
   input wire logic status_clear,
   output logic output_enable,
   output logic oc_fault_status,
   output logic host_notify,
   output logic [2:0] retry_count,
   output logic [15:0] oc_limit,
   output logic [15:0] oc_lv_limit
);

   initial begin
      if (UNIT_W < 1 || UNIT_W > 32) begin
         $error("UNIT_W out of range");
      end
   end

   // Register file
   logic [15:0] overcurrent_fault_threshold;
   logic [7:0] overcurrent_fault_reaction;
   logic [15:0] overcurrent_low_voltage_threshold;
   ocp_pkg::reg_rsp_t next_rsp;

   wire hit_limit = reg_req.cmd == ocp_pkg::CMD_OC_LIMIT;
   wire hit_react = reg_req.cmd == ocp_pkg::CMD_OC_REACT;
   wire hit_lv = reg_req.cmd == ocp_pkg::CMD_OC_LV_LIMIT;
   wire hit_any = hit_limit | hit_react | hit_lv;
   wire access = reg_req.wr | reg_req.rd;
   wire wr_limit = reg_req.wr & hit_limit;
   wire wr_react = reg_req.wr & hit_react;
   wire wr_lv = reg_req.wr & hit_lv;

   wire [15:0] react_word = {8'h00, overcurrent_fault_reaction};
   wire [15:0] rd_mux = hit_limit ? overcurrent_fault_threshold :
                        hit_react ? react_word :
                        hit_lv ? overcurrent_low_voltage_threshold : 16'h0000;

   assign next_rsp.ack = access;
   assign next_rsp.err = access & ~hit_any;
   assign next_rsp.rdata = reg_req.rd ? rd_mux : 16'h0000;

   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         overcurrent_fault_threshold <= ocp_pkg::OC_LIMIT_RST;
      end else if (wr_limit) begin
         overcurrent_fault_threshold <= reg_req.wdata; // [RULE7]
      end
   end

   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         overcurrent_fault_reaction <= ocp_pkg::OC_REACT_RST;
      end else if (wr_react) begin
         overcurrent_fault_reaction <= reg_req.wdata[ocp_pkg::REACT_W-1:0];
      end
   end

   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         overcurrent_low_voltage_threshold <= ocp_pkg::OC_LV_LIMIT_RST;
      end else if (wr_lv) begin
         overcurrent_low_voltage_threshold <= reg_req.wdata; // [RULE11]
      end
   end

   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         reg_rsp <= '0;
      end else begin
         reg_rsp <= next_rsp;
      end
   end

   assign oc_limit = overcurrent_fault_threshold;
   assign oc_lv_limit = overcurrent_low_voltage_threshold;

   // Reaction fields
   ocp_pkg::resp_t resp;
   wire [2:0] retry_set =
      overcurrent_fault_reaction[ocp_pkg::RETRY_HI:ocp_pkg::RETRY_LO]; // [RULE12]
   wire [2:0] delay_code =
      overcurrent_fault_reaction[ocp_pkg::DELAY_HI:ocp_pkg::DELAY_LO];
   assign resp = ocp_pkg::resp_t'(
      overcurrent_fault_reaction[ocp_pkg::RESP_HI:ocp_pkg::RESP_LO]);

   // Doubling table; code 2 falls out as four units
   wire [7:0] delay_units = ocp_pkg::ONE_UNIT << delay_code; // [RULE5] [RULE14]

   // Comparator pin is asynchronous to ref_clk
   logic pin_s1;
   logic pin_s2;
   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         pin_s1 <= 1'b0;
         pin_s2 <= 1'b0;
      end else begin
         pin_s1 <= oc_detect_pin;
         pin_s2 <= pin_s1;
      end
   end
   wire fault = pin_s2;

   // Command edge detection for off-then-on clearing
   logic cmd_on_q;
   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         cmd_on_q <= 1'b0;
      end else begin
         cmd_on_q <= output_cmd_on;
      end
   end
   wire cmd_rise = output_cmd_on & ~cmd_on_q;
   wire clear_any = clear_faults | status_clear | cmd_rise; // [RULE13]
   wire abandon = ~output_cmd_on | other_fault_off; // [RULE4]

   // Delay timer: units of unit_cycles clocks each
   logic [UNIT_W-1:0] unit_cnt;
   logic [7:0] unit_tally;
   logic timer_start;
   wire [UNIT_W:0] unit_cnt_inc = {1'b0, unit_cnt} + {{UNIT_W{1'b0}}, 1'b1};
   // Unit of zero is treated as one clock rather than hanging
   wire unit_wrap = unit_cnt_inc >= {1'b0, unit_cycles};
   wire [7:0] tally_inc = unit_tally + 8'h01;
   wire expire = unit_wrap & (tally_inc == delay_units); // [RULE3] [RULE6]

   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         unit_cnt <= '0;
         unit_tally <= 8'h00;
      end else if (timer_start) begin
         unit_cnt <= '0;
         unit_tally <= 8'h00;
      end else if (unit_wrap) begin
         unit_cnt <= '0;
         unit_tally <= expire ? unit_tally : tally_inc;
      end else begin
         unit_cnt <= unit_cnt_inc[UNIT_W-1:0];
      end
   end

   // Restart sequencer
   ocp_pkg::state_t state;
   ocp_pkg::state_t next_state;
   logic [2:0] attempts;
   logic [2:0] next_attempts;

   wire limited = retry_set != ocp_pkg::RETRY_ENDLESS;
   wire exhausted = limited & (attempts >= retry_set); // [RULE1] [RULE2]
   wire no_retry = retry_set == ocp_pkg::RETRY_NONE;
   wire shut_resp = resp == ocp_pkg::RESP_DISABLE_RETRY ||
                    resp == ocp_pkg::RESP_OFF_RETRY;
   wire [2:0] attempts_inc = attempts == ocp_pkg::RETRY_ENDLESS ?
                             attempts : attempts + 3'h1;

   always_comb begin
      next_state = state;
      next_attempts = attempts;
      timer_start = 1'b0;
      if (abandon || (clear_any && state != ocp_pkg::ST_ON)) begin
         next_state = ocp_pkg::ST_ON; // [RULE13] [RULE4]
         next_attempts = 3'h0; // [RULE15]
      end else begin
         case (state)
            ocp_pkg::ST_ON: begin
               if (fault && resp == ocp_pkg::RESP_RUN_DELAY) begin
                  next_state = ocp_pkg::ST_HOLD; // [RULE6]
                  timer_start = 1'b1;
               end else if (fault && shut_resp) begin
                  if (no_retry) begin
                     next_state = ocp_pkg::ST_LATCH; // [RULE10]
                  end else begin
                     next_state = ocp_pkg::ST_WAIT; // [RULE8]
                     timer_start = 1'b1;
                  end
               end
            end
            ocp_pkg::ST_HOLD: begin
               if (!fault) begin
                  next_state = ocp_pkg::ST_ON;
               end else if (expire) begin
                  next_state = no_retry ? ocp_pkg::ST_LATCH : ocp_pkg::ST_WAIT;
                  timer_start = 1'b1;
               end
            end
            ocp_pkg::ST_WAIT: begin
               if (expire) begin
                  next_state = ocp_pkg::ST_TRY; // [RULE3]
                  next_attempts = attempts_inc; // [RULE12]
                  timer_start = 1'b1;
               end
            end
            ocp_pkg::ST_TRY: begin
               if (fault) begin
                  // Timer keeps running so attempt starts stay evenly spaced
                  next_state = exhausted ? ocp_pkg::ST_LATCH : ocp_pkg::ST_WAIT; // [RULE2]
               end else if (expire) begin
                  next_state = ocp_pkg::ST_ON;
                  next_attempts = 3'h0; // [RULE15]
               end
            end
            ocp_pkg::ST_LATCH: begin
               next_state = ocp_pkg::ST_LATCH; // [RULE2] [RULE10]
            end
            default: begin
               next_state = ocp_pkg::ST_ON;
               next_attempts = 3'h0;
            end
         endcase
      end
   end

   wire next_out_on = ~abandon & (next_state == ocp_pkg::ST_ON ||
                                  next_state == ocp_pkg::ST_HOLD ||
                                  next_state == ocp_pkg::ST_TRY);

   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         state <= ocp_pkg::ST_ON;
         attempts <= 3'h0;
         output_enable <= 1'b0;
      end else begin
         state <= next_state;
         attempts <= next_attempts;
         output_enable <= next_out_on;
      end
   end

   assign retry_count = attempts;

   // Sticky status; a fault in the clearing cycle wins
   wire fault_seen = fault & output_enable;
   wire next_status = fault_seen | (oc_fault_status & ~(clear_faults | status_clear));
   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         oc_fault_status <= 1'b0;
         host_notify <= 1'b0;
      end else begin
         oc_fault_status <= next_status; // [RULE9]
         host_notify <= next_status; // [RULE9]
      end
   end

endmodule : overcurrent_fault_retry_logic
